// *** design/sfrw_pkg.sv ***
package sfrw_pkg;
   // -----------------------------------------------------------------
   // command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_WREN  = 8'h06;
   localparam logic [7:0] CMD_WRSR  = 8'h01;
   localparam logic [7:0] CMD_WRNV  = 8'hb1;
   localparam logic [7:0] CMD_WRVC  = 8'h81;
   localparam logic [7:0] CMD_WREV  = 8'h61;
   localparam logic [7:0] CMD_WREA  = 8'hc5;
   localparam logic [7:0] CMD_CLRFS = 8'h50;
   localparam logic [7:0] CMD_PROG  = 8'h02;
   // -----------------------------------------------------------------
   // bit positions
   // -----------------------------------------------------------------
   localparam int SR_WIP     = 0;
   localparam int SR_WEL     = 1;
   localparam int SR_LOCK    = 7;
   localparam int FS_PROT    = 1;
   localparam int FS_PROG    = 4;
   localparam int FS_ERASE   = 5;
   localparam int FS_READY   = 7;
   localparam int PIN_LANE0  = 0;
   localparam int PIN_SCLK   = 4;
   localparam int PIN_CS     = 5;
   localparam int PIN_WP     = 6;
   localparam int PIN_W      = 7;
   // -----------------------------------------------------------------
   // reset values and writable masks
   // -----------------------------------------------------------------
   localparam logic [7:0]  SR_RST    = 8'h00;
   localparam logic [7:0]  FS_RST    = 8'h80;
   localparam logic [15:0] NV_RST    = 16'hffff;
   localparam logic [7:0]  VC_RST    = 8'hfb;
   localparam logic [7:0]  EV_RST    = 8'hff;
   localparam logic [7:0]  EA_RST    = 8'h00;
   localparam logic [7:0]  VC_MASK   = 8'hfb;
   localparam logic [7:0]  EV_MASK   = 8'hef;
   localparam logic [7:0]  EA_MASK   = 8'h01;
   localparam logic [7:0]  FS_CLR    = 8'h32;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ                   = 200;
   localparam int STATUS_WRITE_TIME_US      = 8;
   localparam int NONVOLATILE_CFG_WRITE_TIME_US = 16;
   localparam int PROG_TIMEOUT_US           = 20;
   localparam logic [15:0] STATUS_WRITE_CYC =
      16'(STATUS_WRITE_TIME_US * CLK_MHZ);
   localparam logic [15:0] NONVOLATILE_CFG_WRITE_CYC =
      16'(NONVOLATILE_CFG_WRITE_TIME_US * CLK_MHZ);
   localparam logic [15:0] PROG_TIMEOUT_CYC =
      16'(PROG_TIMEOUT_US * CLK_MHZ);
   localparam int PROG_MIN_BYTES = 5;
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      PROTO_EXT  = 2'b00,
      PROTO_DUAL = 2'b01,
      PROTO_QUAD = 2'b10
   } sfrw_proto_t;
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_REG  = 2'b01,
      OP_PROG = 2'b10
   } sfrw_op_t;
endpackage

// *** design/sfrw_core.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - bits arrive on one, two or four lanes, command then data.
// - chip select off byte boundary: only 50h acts; nothing else runs, no flags set, latch stays set.
// - status and nonvolatile writes are self-timed with their own durations.
// - status write changes bits 7..2 only.
// - busy bit clears at completion; status stays readable throughout.
// - volatile, enhanced and extended writes act at once, reserved bits kept.
// - 01h writes status, B1h writes nonvolatile configuration.
// - 81h, 61h, C5h write volatile, enhanced, extended address.
// - status lock bit with write-protect pin blocks status writes.
// - 50h clears erase, program and protection error flags.
// - address bits sampled on serial clock rising edge.
// - program to protected sector: no run, latch stays, flags 1 and 4.
// - program timeout clears write enable and sets program-fail flag.
// - act only when the clocked bit count is a whole byte multiple, except 50h.
// - 06h sets the write enable latch.
module sfrw_core (
   input  wire logic                ref_clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                cs_n_i,
   input  wire logic                sclk_i,
   input  wire logic [3:0]          serial_lane_i,
   input  wire logic                wp_n_i,
   input  wire sfrw_pkg::sfrw_proto_t proto_i,
   input  wire logic                sector_prot_i,
   input  wire logic                array_done_i,
   output logic      [7:0]          status_o,
   output logic      [7:0]          flag_o,
   output logic      [15:0]         nvcfg_o,
   output logic      [7:0]          vcfg_o,
   output logic      [7:0]          evcfg_o,
   output logic      [7:0]          ext_addr_o,
   output logic                     prog_start_o,
   output logic      [23:0]         prog_addr_o
);
   import sfrw_pkg::*;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] lane_width(input sfrw_proto_t p);
      case (p)
         PROTO_DUAL: lane_width = 4'h2;
         PROTO_QUAD: lane_width = 4'h4;
         default:    lane_width = 4'h1;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q, pin_d, pins;

   assign pins = {wp_n_i, cs_n_i, sclk_i, serial_lane_i};

   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s1_q  <= 7'h60;
         s2_q  <= 7'h60;
         s3_q  <= 7'h60;
         pin_q <= 7'h60;
      end else begin
         s1_q  <= pins;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   logic sclk_rise, cs_fall, cs_rise, locked;
   assign sclk_rise = pin_d[PIN_SCLK] & ~pin_q[PIN_SCLK] & ~pin_q[PIN_CS];
   assign cs_fall   = ~pin_d[PIN_CS] & pin_q[PIN_CS];
   assign cs_rise   = pin_d[PIN_CS] & ~pin_q[PIN_CS];

   // -----------------------------------------------------------------
   // frame and control state
   // -----------------------------------------------------------------
   logic [7:0]  sh_q, sh_d, nb, cmd_q, cmd_d, d0_q, d0_d, d1_q, d1_d;
   logic [3:0]  bcnt_q, bcnt_d, bsum;
   logic [2:0]  nbyt_q, nbyt_d;
   logic [23:0] addr_q, addr_d;
   logic [7:0]  sr_q, sr_d, fs_q, fs_d, vc_q, vc_d, ev_q, ev_d, ea_q, ea_d;
   logic [15:0] nv_q, nv_d, tmr_q, tmr_d;
   sfrw_op_t    op_q, op_d;
   logic        ps_q, ps_d, whole, idle, wel, go_wren, go_wrsr, go_wrnv;
   logic        go_vol, go_clr, go_prog, tout;

   assign locked = sr_q[SR_LOCK] & ~pin_q[PIN_WP];
   assign whole  = (bcnt_q == 4'h0);
   assign idle   = (op_q == OP_IDLE);
   assign wel    = sr_q[SR_WEL];
   assign bsum   = bcnt_q + lane_width(proto_i);

   always_comb begin
      case (proto_i)
         PROTO_QUAD: nb = {sh_q[3:0], pin_q[PIN_LANE0 +: 4]};
         PROTO_DUAL: nb = {sh_q[5:0], pin_q[PIN_LANE0 +: 2]};
         default:    nb = {sh_q[6:0], pin_q[PIN_LANE0]};
      endcase
   end

   // command decode at chip select release, whole bytes only except 50h
   assign go_wren = cs_rise & whole & idle & (cmd_q == CMD_WREN)
                  & (nbyt_q == 3'h1);
   assign go_wrsr = cs_rise & whole & idle & wel & (cmd_q == CMD_WRSR)
                  & (nbyt_q == 3'h2);
   assign go_wrnv = cs_rise & whole & idle & wel & (cmd_q == CMD_WRNV)
                  & (nbyt_q == 3'h3);
   assign go_vol  = cs_rise & whole & idle & wel & (nbyt_q == 3'h2)
                  & ((cmd_q == CMD_WRVC) | (cmd_q == CMD_WREV)
                  | (cmd_q == CMD_WREA));
   assign go_clr  = cs_rise & (cmd_q == CMD_CLRFS)
                  & (nbyt_q != 3'h0);
   assign go_prog = cs_rise & whole & idle & wel & (cmd_q == CMD_PROG)
                  & (nbyt_q >= 3'(PROG_MIN_BYTES));
   assign tout    = (op_q == OP_PROG) & (tmr_q == 16'h0001) & ~array_done_i;

   always_comb begin
      sh_d   = sh_q;
      bcnt_d = bcnt_q;
      nbyt_d = nbyt_q;
      cmd_d  = cmd_q;
      d0_d   = d0_q;
      d1_d   = d1_q;
      addr_d = addr_q;
      sr_d   = sr_q;
      fs_d   = fs_q;
      nv_d   = nv_q;
      vc_d   = vc_q;
      ev_d   = ev_q;
      ea_d   = ea_q;
      op_d   = op_q;
      tmr_d  = tmr_q;
      ps_d   = 1'b0;
      if (cs_fall) begin
         bcnt_d = 4'h0;
         nbyt_d = 3'h0;
         cmd_d  = 8'h00;
      end else if (sclk_rise) begin
         sh_d = nb;
         if (bsum == 4'h8) begin
            bcnt_d = 4'h0;
            if (nbyt_q != 3'h7) begin
               nbyt_d = nbyt_q + 3'h1;
            end
            case (nbyt_q)
               3'h0: cmd_d = nb;
               3'h1: d0_d  = nb;
               3'h2: d1_d  = nb;
               default: ;
            endcase
            if ((nbyt_q != 3'h0) && (nbyt_q < 3'h4)) begin
               addr_d = {addr_q[15:0], nb};
            end
         end else begin
            bcnt_d = bsum;
         end
      end
      // timed operations
      case (op_q)
         OP_REG: begin
            tmr_d = tmr_q - 16'h0001;
            if (tmr_q == 16'h0001) begin
               op_d         = OP_IDLE;
               sr_d[SR_WIP] = 1'b0;
            end
         end
         OP_PROG: begin
            tmr_d = tmr_q - 16'h0001;
            if (array_done_i || tout) begin
               op_d         = OP_IDLE;
               sr_d[SR_WIP] = 1'b0;
               sr_d[SR_WEL] = 1'b0;
            end
         end
         default: begin
            if (go_wren) begin
               sr_d[SR_WEL] = 1'b1;
            end
            if (go_wrsr) begin
               if (!locked) begin
                  sr_d[7:2] = d0_q[7:2];
               end
               sr_d[SR_WIP] = 1'b1;
               sr_d[SR_WEL] = 1'b0;
               op_d         = OP_REG;
               tmr_d        = STATUS_WRITE_CYC;
            end
            if (go_wrnv) begin
               nv_d         = {d1_q, d0_q};
               sr_d[SR_WIP] = 1'b1;
               sr_d[SR_WEL] = 1'b0;
               op_d         = OP_REG;
               tmr_d        = NONVOLATILE_CFG_WRITE_CYC;
            end
            if (go_vol) begin
               sr_d[SR_WEL] = 1'b0;
               case (cmd_q)
                  CMD_WRVC: vc_d = (vc_q & ~VC_MASK) | (d0_q & VC_MASK);
                  CMD_WREV: ev_d = (ev_q & ~EV_MASK) | (d0_q & EV_MASK);
                  default:  ea_d = (ea_q & ~EA_MASK) | (d0_q & EA_MASK);
               endcase
            end
            if (go_prog) begin
               if (sector_prot_i) begin
                  fs_d[FS_PROT] = 1'b1;
                  fs_d[FS_PROG] = 1'b1;
               end else begin
                  op_d         = OP_PROG;
                  sr_d[SR_WIP] = 1'b1;
                  tmr_d        = PROG_TIMEOUT_CYC;
                  ps_d         = 1'b1;
               end
            end
         end
      endcase
      if (go_clr) begin
         fs_d = fs_d & ~FS_CLR;
      end
      if (tout) begin
         fs_d[FS_PROG] = 1'b1;
      end
      fs_d[FS_READY] = (op_d == OP_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sh_q   <= 8'h00;
         bcnt_q <= 4'h0;
         nbyt_q <= 3'h0;
         cmd_q  <= 8'h00;
         d0_q   <= 8'h00;
         d1_q   <= 8'h00;
         addr_q <= 24'h000000;
         sr_q   <= SR_RST;
         fs_q   <= FS_RST;
         nv_q   <= NV_RST;
         vc_q   <= VC_RST;
         ev_q   <= EV_RST;
         ea_q   <= EA_RST;
         op_q   <= OP_IDLE;
         tmr_q  <= 16'h0000;
         ps_q   <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         bcnt_q <= bcnt_d;
         nbyt_q <= nbyt_d;
         cmd_q  <= cmd_d;
         d0_q   <= d0_d;
         d1_q   <= d1_d;
         addr_q <= addr_d;
         sr_q   <= sr_d;
         fs_q   <= fs_d;
         nv_q   <= nv_d;
         vc_q   <= vc_d;
         ev_q   <= ev_d;
         ea_q   <= ea_d;
         op_q   <= op_d;
         tmr_q  <= tmr_d;
         ps_q   <= ps_d;
      end
   end

   assign status_o     = sr_q;
   assign flag_o       = fs_q;
   assign nvcfg_o      = nv_q;
   assign vcfg_o       = vc_q;
   assign evcfg_o      = ev_q;
   assign ext_addr_o   = ea_q;
   assign prog_start_o = ps_q;
   assign prog_addr_o  = addr_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   wel_set_a: assert property (go_wren |=> sr_q[SR_WEL])
      else $error("write enable not set");
   wsr_bits_a: assert property (go_wrsr |=>
      sr_q[7:2] == ($past(locked) ? $past(sr_q[7:2]) : $past(d0_q[7:2])))
      else $error("status write bits wrong");
   wip_hold_a: assert property ((go_wrsr || go_wrnv) |=>
      sr_q[SR_WIP] && !sr_q[SR_WEL] && op_q == OP_REG)
      else $error("busy or latch wrong at start");
   wip_clear_a: assert property ((op_q == OP_REG && tmr_q == 16'h0001) |=>
      !sr_q[SR_WIP] && op_q == OP_IDLE)
      else $error("busy bit not cleared");
   partial_a: assert property ((cs_rise && !whole && idle && cmd_q != CMD_CLRFS) |=>
      $stable(sr_q[7:1]) && $stable(fs_q[6:0]))
      else $error("partial frame acted");
   clr_flag_a: assert property ((go_clr && !tout) |=>
      !fs_q[FS_PROT] && !fs_q[FS_PROG] && !fs_q[FS_ERASE])
      else $error("error flags not cleared");
   prot_a: assert property ((go_prog && sector_prot_i) |=>
      fs_q[FS_PROT] && fs_q[FS_PROG] && sr_q[SR_WEL] && op_q == OP_IDLE)
      else $error("protected program handled wrong");
   tout_a: assert property (tout |=>
      fs_q[FS_PROG] && !sr_q[SR_WEL] && !sr_q[SR_WIP])
      else $error("timeout handled wrong");
   nv_order_a: assert property (go_wrnv |=>
      nv_q == {$past(d1_q), $past(d0_q)})
      else $error("nonvolatile byte order wrong");
   vol_mask_a: assert property ((go_vol && cmd_q == CMD_WRVC) |=>
      (vc_q & ~VC_MASK) == ($past(vc_q) & ~VC_MASK))
      else $error("reserved bits changed");
   no_wel_a: assert property ((cs_rise && !wel && idle) |=>
      $stable(nv_q) && !sr_q[SR_WIP] && !ps_q)
      else $error("write ran without enable");

   wrsr_c: cover property (go_wrsr ##1 (op_q == OP_REG) [*8]);
   prog_c: cover property (go_prog && !sector_prot_i);
   tout_c: cover property (tout);
   clr_c: cover property (go_clr);
endmodule // sfrw_core

// *** tb/sfrw_host.sv ***
`timescale 1ns/10ps
module sfrw_host (
   input  wire logic                  ref_clk_i,
   input  wire sfrw_pkg::sfrw_proto_t proto_i,
   output logic                       cs_n_o,
   output logic                       sclk_o,
   output logic [3:0]                 lane_o
);
   import sfrw_pkg::*;
   // -----------------------------------------------------------------
   // frame driver, 48 ns serial clock, idle low between frames
   // -----------------------------------------------------------------
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      lane_o = 4'h5;
   end
   task automatic frame(input logic [39:0] data, input int nbits);
      int          w;
      int          i;
      logic [39:0] sh;
      w = (proto_i == PROTO_QUAD) ? 4 : (proto_i == PROTO_DUAL) ? 2 : 1;
      @(posedge ref_clk_i);
      #1 cs_n_o = 1'b0;
      for (i = 0; i < nbits; i += w) begin
         sh = data << i;
         #12 lane_o = sh[39:36] >> (4 - w);
         #12 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      lane_o = ~lane_o;
      #100;
   endtask
endmodule // sfrw_host

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import sfrw_pkg::*;
   logic         ref_clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic         wp_n, sector_prot, array_done, cs_n, sclk, prog_start;
   sfrw_proto_t  proto;
   logic [3:0]   lanes;
   logic [7:0]   status, flag, vcfg, evcfg, ext_addr, d, d2, sr;
   logic [15:0]  nvcfg;
   logic [23:0]  prog_addr, a, paddr;
   logic [7:0]   vcmd [3] = '{CMD_WRVC, CMD_WREV, CMD_WREA};
   logic [7:0]   vmsk [3] = '{VC_MASK, EV_MASK, EA_MASK};
   logic [7:0]   vmdl [3] = '{VC_RST, EV_RST, EA_RST};
   int           err_total = 0, num_checks = 0, cyc = 0, starts = 0, seed, p, k;
   always #2.5 ref_clk = ~ref_clk;
   sfrw_host host_u (.ref_clk_i(ref_clk), .proto_i(proto), .cs_n_o(cs_n), .sclk_o(sclk),
                     .lane_o(lanes));
   sfrw_core dut_u (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .cs_n_i(cs_n), .sclk_i(sclk),
                    .serial_lane_i(lanes), .wp_n_i(wp_n), .proto_i(proto),
                    .sector_prot_i(sector_prot), .array_done_i(array_done),
                    .status_o(status), .flag_o(flag), .nvcfg_o(nvcfg), .vcfg_o(vcfg),
                    .evcfg_o(evcfg), .ext_addr_o(ext_addr), .prog_start_o(prog_start),
                    .prog_addr_o(prog_addr));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [7:0] vol_exp(logic [7:0] old, logic [7:0] nw, logic [7:0] m);
      return (old & ~m) | (nw & m);
   endfunction
   function automatic logic [7:0] vseen(int i);
      return (i == 0) ? vcfg : (i == 1) ? evcfg : ext_addr;
   endfunction
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wren();
      host_u.frame({CMD_WREN, 32'h0}, 8);
      check(24'(status[SR_WEL]), 24'h1, "latch set");
   endtask
   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      while (status[SR_WIP] === 1'b1 && n < lim + 100) begin
         step();
         n++;
      end
      check(24'(n > lim - 60 && n <= lim), 24'h1, "busy length");
      check(24'(flag[FS_READY]), 24'h1, "ready");
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (prog_start === 1'b1) begin
         starts <= starts + 1;
         paddr <= prog_addr;
      end
      if (cyc == 60000) begin
         err_total++;
         $display("BAD t=%0t run too long", $time);
         report_and_stop();
      end
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      seed = 11;
      wp_n = 1'b1;
      proto = PROTO_EXT;
      sector_prot = 1'b0;
      array_done = 1'b0;
      sr = SR_RST;
      repeat (10) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check({status, flag, vcfg}, {SR_RST, FS_RST, VC_RST}, "reset regs");
      check({nvcfg, evcfg}, {NV_RST, EV_RST}, "reset cfg");
      check(24'(ext_addr), 24'(EA_RST), "reset ext");
      host_u.frame({CMD_WRSR, 8'hfc, 24'h0}, 16);
      check(24'(status), 24'(SR_RST), "write without latch");
      wren();
      host_u.frame({CMD_WRSR, 8'hfc, 24'h0}, 15);
      host_u.frame({CMD_PROG, 24'h123456, 8'h5a}, 39);
      check({status, flag}, {8'h02, FS_RST}, "partial frame");
      check(24'(starts), 24'h0, "partial program");
      $display("test refusals done");
      for (k = 0; k < 3; k++) begin
         d = 8'($random(seed));
         d[SR_LOCK] = (k == 0);
         step();
         wp_n = (k != 1);
         wren();
         host_u.frame({CMD_WRSR, d, 24'h0}, 16);
         if (k != 1) sr = {d[7:2], 2'b00};
         check({status, flag[FS_READY]}, {sr[7:2], 2'b01, 1'b0}, "status busy");
         wait_idle(int'(STATUS_WRITE_CYC));
         check(24'(status), 24'(sr), "status done");
      end
      wren();
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      host_u.frame({CMD_WRNV, d, d2, 16'h0}, 24);
      check(24'(status[1:0]), 24'h1, "nv busy");
      wait_idle(int'(NONVOLATILE_CFG_WRITE_CYC));
      check(24'(nvcfg), {8'h0, d2, d}, "nv value");
      $display("test timed writes done");
      for (p = 0; p < 3; p++) begin
         for (k = 0; k < 3; k++) begin
            step();
            proto = sfrw_proto_t'(2'(p));
            wren();
            d = 8'($random(seed));
            host_u.frame({vcmd[k], d, 24'h0}, 16);
            vmdl[k] = vol_exp(vmdl[k], d, vmsk[k]);
            check(24'(vseen(k)), 24'(vmdl[k]), "volatile reg");
         end
      end
      $display("test volatile writes done");
      step();
      sector_prot = 1'b1;
      wren();
      a = 24'($random(seed));
      host_u.frame({CMD_PROG, a, 8'h3c}, 40);
      check({status, flag & 8'h12}, {sr | 8'h02, 8'h12}, "protected");
      check(24'(starts), 24'h0, "protected start");
      step();
      sector_prot = 1'b0;
      proto = PROTO_EXT;
      host_u.frame({CMD_CLRFS, 32'h0}, 11);
      check(24'(flag), 24'(FS_RST), "flags cleared");
      for (k = 0; k < 2; k++) begin
         wren();
         a = 24'($random(seed));
         host_u.frame({CMD_PROG, a, 8'ha5}, 40);
         check(24'(starts), 24'(k + 1), "program start");
         check(paddr, a, "program address");
         check(24'(status[1:0]), 24'h3, "program busy");
         if (k == 0) begin
            step();
            array_done = 1'b1;
            step();
            array_done = 1'b0;
            repeat (3) step();
            check({status, flag}, {sr, FS_RST}, "program done");
         end else begin
            wait_idle(int'(PROG_TIMEOUT_CYC));
            check({flag[FS_PROG], status[SR_WEL]}, 24'h2, "program timeout");
         end
      end
      $display("test program done");
      report_and_stop();
   end
endmodule // testbench
